//--- dv/peripheral_module_disable_tb_top.sv
module peripheral_module_disable_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic [15:0] regRdata;
  logic [15:0] rd;
  pmd_pkg::off_vec_t offVec;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  peripheral_module_disable peripheral_module_disable_i (
    .clk_sys(clk_sys),
    .srst(srst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .offVec(offVec)
  );

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ceiling well above the roughly 60 cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge clk_sys);
    regWr <= 1'h0;
    #1;
  endtask

  task automatic rdr(logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk_sys);
    regRd <= 1'h0;
    #1;
    rd = regRdata;
  endtask

  task automatic reset_values();
    rdr(pmd_pkg::DisableRegAddr);
    chk("disable reg", 16'h0000, rd);
    chk("offVec", 16'h0000, {11'h000, offVec});
  endtask

  task automatic each_bit();
    int pos[5] = '{5, 7, 9, 11, 12};
    for (int i = 0; i < 5; i++) begin
      wr(pmd_pkg::DisableRegAddr, 16'h0001 << pos[i]);
      chk("offVec", 16'h0001 << i, {11'h000, offVec});
      rdr(pmd_pkg::DisableRegAddr);
      chk("readback", 16'h0001 << pos[i], rd);
    end
    wr(pmd_pkg::DisableRegAddr, 16'h0000);
    chk("offVec clear", 16'h0000, {11'h000, offVec});
  endtask

  task automatic unimplemented_bits();
    wr(pmd_pkg::DisableRegAddr, 16'h0550);
    rdr(pmd_pkg::DisableRegAddr);
    chk("holes only", 16'h0000, rd);
    wr(pmd_pkg::DisableRegAddr, 16'hFFFF);
    chk("offVec all", 16'h001F, {11'h000, offVec});
    rdr(pmd_pkg::DisableRegAddr);
    chk("all ones", 16'h1AA0, rd);
    rdr(pmd_pkg::StatusRegAddr);
    chk("status", 16'h0001, rd);
    wr(pmd_pkg::StatusRegAddr, 16'h0000);
    wr(4'h2, 16'h0000);
    chk("offVec kept", 16'h001F, {11'h000, offVec});
    rdr(4'h2);
    chk("unmapped", 16'h0000, rd);
    // reset in mid-run re-enables every unit
    @(posedge clk_sys);
    srst <= 1'h1;
    @(posedge clk_sys);
    srst <= 1'h0;
    #1;
    chk("offVec reset", 16'h0000, {11'h000, offVec});
  endtask

  task automatic back_to_back();
    // write then read on the next cycle, holes 4, 6, 8 and 10 written as ones along with timer B bit 12
    @(posedge clk_sys);
    regAddr <= pmd_pkg::DisableRegAddr;
    regWdata <= 16'h1550;
    regWr <= 1'h1;
    @(posedge clk_sys);
    regWr <= 1'h0;
    regRd <= 1'h1;
    @(posedge clk_sys);
    regRd <= 1'h0;
    #1;
    chk("b2b read", 16'h1000, regRdata);
    chk("b2b offVec", 16'h0010, {11'h000, offVec});
    @(posedge clk_sys);
    #1;
    chk("read gone", 16'h0000, regRdata);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'h0;
    reset_values();
    each_bit();
    unimplemented_bits();
    back_to_back();
    report_and_stop();
  end
endmodule

//--- hdl/off_bit.sv
module off_bit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // control
  input wire logic load,
  input wire logic dIn,
  // state
  output logic q
);

  logic bit_r;
  logic bit_nxt;

  always_comb begin
    bit_nxt = bit_r;
    if (load) begin
      bit_nxt = dIn;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bit_r <= 1'h0;
    end else begin
      bit_r <= bit_nxt;
    end
  end

  assign q = bit_r;

endmodule

//--- hdl/peripheral_module_disable.sv
// Implementation choices: the address-and-strobe port and the register offsets.
module peripheral_module_disable #(
  parameter int DataWidth = pmd_pkg::DataWidth
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // peripheral disables
  output pmd_pkg::off_vec_t offVec
);

  localparam int NumBits = 5;
  localparam int BitPos [NumBits] = '{
    pmd_pkg::TimerBBit, pmd_pkg::TimerABit, pmd_pkg::PulseBit,
    pmd_pkg::TwoWireBit, pmd_pkg::SerialBit};

  // refuse parameters the fixed register map cannot serve
  if (DataWidth != 16) begin : gBadWidth
    $error("only a 16-bit data width is supported");
  end

  for (genvar ci = 0; ci < NumBits; ci++) begin : gPosCheck
    if (BitPos[ci] >= DataWidth) begin : gBadPos
      $error("disable bit lies outside the data word");
    end else if (!pmd_pkg::ImplMask[BitPos[ci]]) begin : gBadMask
      $error("disable bit missing from the implemented mask");
    end
  end

  if ($countones(pmd_pkg::ImplMask) != NumBits) begin : gBadCount
    $error("implemented mask and disable bits disagree");
  end

  pmd_pkg::reg_req_t req;
  logic [NumBits-1:0] offBits;
  logic [15:0] disableView;
  logic ldDisable;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign ldDisable = req.wr && (req.addr == pmd_pkg::DisableRegAddr);

  genvar gi;
  generate
    for (gi = 0; gi < NumBits; gi++) begin : gBits
      off_bit uBit (
        .clk_sys(clk_sys),
        .srst(srst),
        .load(ldDisable),
        .dIn(req.wdata[BitPos[gi]]),
        .q(offBits[gi])
      );
    end
  endgenerate

  always_comb begin
    disableView = 16'h0000;
    for (int i = 0; i < NumBits; i++) begin
      disableView[BitPos[i]] = offBits[i];
    end
  end

  // status mirrors whether any unit is held off in bit 0
  always_comb begin
    rdata_nxt = 16'h0000;
    if (req.rd) begin
      case (req.addr)
        pmd_pkg::DisableRegAddr: rdata_nxt = disableView & pmd_pkg::ImplMask;
        pmd_pkg::StatusRegAddr: rdata_nxt = {15'h0000, |offBits};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign regRdata = rdata_r;
  assign offVec = '{timerBOff: offBits[0], timerAOff: offBits[1],
    pulseUnitOff: offBits[2], twoWireUnitOff: offBits[3],
    serialPortOff: offBits[4]};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  timer_b_write_a: assert property (ldDisable |=>
    offVec.timerBOff == $past(regWdata[pmd_pkg::TimerBBit]))
    else $error("second timer off bit did not follow write");
  timer_a_write_a: assert property (ldDisable |=>
    offVec.timerAOff == $past(regWdata[pmd_pkg::TimerABit]))
    else $error("first timer off bit did not follow write");
  pulse_write_a: assert property (ldDisable |=>
    offVec.pulseUnitOff == $past(regWdata[pmd_pkg::PulseBit]))
    else $error("pulse unit off bit did not follow write");
  two_wire_write_a: assert property (ldDisable |=>
    offVec.twoWireUnitOff == $past(regWdata[pmd_pkg::TwoWireBit]))
    else $error("two-wire off bit did not follow write");
  serial_write_a: assert property (ldDisable |=>
    offVec.serialPortOff == $past(regWdata[pmd_pkg::SerialBit]))
    else $error("serial port off bit did not follow write");
  reserved_zero_a: assert property (
    (regRd && regAddr == pmd_pkg::DisableRegAddr) |=>
    (regRdata & ~pmd_pkg::ImplMask) == 16'h0000)
    else $error("unimplemented bit read as one");
  read_back_a: assert property (
    (regRd && regAddr == pmd_pkg::DisableRegAddr) |=>
    regRdata[pmd_pkg::TimerBBit] == offVec.timerBOff &&
    regRdata[pmd_pkg::SerialBit] == offVec.serialPortOff)
    else $error("read data does not match off outputs");
  hold_a: assert property (!ldDisable && !srst |=> $stable(offVec))
    else $error("off outputs changed without a write");
  reset_clear_a: assert property (@(posedge clk_sys)
    $past(srst) |-> offVec == '0)
    else $error("off outputs not cleared by reset");

  // each unit holds between writes; the reset edge is left out
  timer_b_hold_a: assert property (
    !ldDisable && !srst |=> $stable(offVec.timerBOff))
    else $error("second timer off bit moved without a write");
  timer_a_hold_a: assert property (
    !ldDisable && !srst |=> $stable(offVec.timerAOff))
    else $error("first timer off bit moved without a write");
  pulse_hold_a: assert property (
    !ldDisable && !srst |=> $stable(offVec.pulseUnitOff))
    else $error("pulse unit off bit moved without a write");
  two_wire_hold_a: assert property (
    !ldDisable && !srst |=> $stable(offVec.twoWireUnitOff))
    else $error("two-wire off bit moved without a write");
  serial_hold_a: assert property (
    !ldDisable && !srst |=> $stable(offVec.serialPortOff))
    else $error("serial port off bit moved without a write");

  // each off output shows in its own read position
  timer_b_read_a: assert property (
    (regRd && regAddr == pmd_pkg::DisableRegAddr) |=>
    regRdata[pmd_pkg::TimerBBit] == $past(offVec.timerBOff))
    else $error("second timer bit read back wrong");
  timer_a_read_a: assert property (
    (regRd && regAddr == pmd_pkg::DisableRegAddr) |=>
    regRdata[pmd_pkg::TimerABit] == $past(offVec.timerAOff))
    else $error("first timer bit read back wrong");
  pulse_read_a: assert property (
    (regRd && regAddr == pmd_pkg::DisableRegAddr) |=>
    regRdata[pmd_pkg::PulseBit] == $past(offVec.pulseUnitOff))
    else $error("pulse unit bit read back wrong");
  two_wire_read_a: assert property (
    (regRd && regAddr == pmd_pkg::DisableRegAddr) |=>
    regRdata[pmd_pkg::TwoWireBit] == $past(offVec.twoWireUnitOff))
    else $error("two-wire bit read back wrong");
  serial_read_a: assert property (
    (regRd && regAddr == pmd_pkg::DisableRegAddr) |=>
    regRdata[pmd_pkg::SerialBit] == $past(offVec.serialPortOff))
    else $error("serial port bit read back wrong");

  // every unit comes out of reset enabled
  timer_b_reset_a: assert property (@(posedge clk_sys)
    $past(srst) |-> !offVec.timerBOff)
    else $error("second timer still off after reset");
  timer_a_reset_a: assert property (@(posedge clk_sys)
    $past(srst) |-> !offVec.timerAOff)
    else $error("first timer still off after reset");
  pulse_reset_a: assert property (@(posedge clk_sys)
    $past(srst) |-> !offVec.pulseUnitOff)
    else $error("pulse unit still off after reset");
  two_wire_reset_a: assert property (@(posedge clk_sys)
    $past(srst) |-> !offVec.twoWireUnitOff)
    else $error("two-wire unit still off after reset");
  serial_reset_a: assert property (@(posedge clk_sys)
    $past(srst) |-> !offVec.serialPortOff)
    else $error("serial port still off after reset");

  // register read path
  full_word_a: assert property (
    (regRd && regAddr == pmd_pkg::DisableRegAddr) |=>
    regRdata == {3'h0, $past(offVec.timerBOff), $past(offVec.timerAOff),
      1'h0, $past(offVec.pulseUnitOff), 1'h0, $past(offVec.twoWireUnitOff),
      1'h0, $past(offVec.serialPortOff), 5'h00})
    else $error("disable register read does not match off outputs");
  write_read_a: assert property (
    ldDisable ##1 (regRd && regAddr == pmd_pkg::DisableRegAddr) |=>
    regRdata == ($past(regWdata, 2) & pmd_pkg::ImplMask))
    else $error("written word not read back through the mask");
  read_idle_a: assert property (!regRd |=> regRdata == 16'h0000)
    else $error("read data present without a read");
  status_read_a: assert property (
    (regRd && regAddr == pmd_pkg::StatusRegAddr) |=>
    regRdata == {15'h0000, $past(|offVec)})
    else $error("status word does not reflect the off outputs");
  unmapped_read_a: assert property (
    (regRd && regAddr != pmd_pkg::DisableRegAddr &&
    regAddr != pmd_pkg::StatusRegAddr) |=> regRdata == 16'h0000)
    else $error("unmapped index read as nonzero");
  reset_view_a: assert property (@(posedge clk_sys)
    $past(srst) |-> disableView == pmd_pkg::DisableReset)
    else $error("disable register not at its reset value");

  write_all_c: cover property (ldDisable && regWdata == 16'hFFFF);
  read_disable_c: cover property (regRd &&
    regAddr == pmd_pkg::DisableRegAddr ##1 regRdata != 16'h0000);
  write_read_c: cover property (ldDisable ##1 regRd);
  status_set_c: cover property (regRd &&
    regAddr == pmd_pkg::StatusRegAddr ##1 regRdata[0]);
  holes_write_c: cover property (ldDisable &&
    (regWdata & ~pmd_pkg::ImplMask) != 16'h0000);

endmodule

//--- hdl/pmd_pkg.sv
package pmd_pkg;

  localparam int DataWidth = 16;
  localparam int AddrWidth = 4;

  // register indices (word addressed plain port)
  localparam logic [3:0] DisableRegAddr = 4'h0;
  localparam logic [3:0] StatusRegAddr = 4'h1;

  // bit positions in the disable register
  localparam int TimerBBit = 12;
  localparam int TimerABit = 11;
  localparam int PulseBit = 9;
  localparam int TwoWireBit = 7;
  localparam int SerialBit = 5;

  localparam logic [15:0] ImplMask = 16'h1AA0;
  localparam logic [15:0] DisableReset = 16'h0000;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic timerBOff;
    logic timerAOff;
    logic pulseUnitOff;
    logic twoWireUnitOff;
    logic serialPortOff;
  } off_vec_t;

endpackage
